// >>> hdl/gdc_regs.sv
`include "gdc_defs.svh"

// Function
// - setpoint write starts calculation, loads per select
// - setpoint commands 40h and 42h
// - low twelve bits kept, reset zero
// - K commands 44h and 46h, no reset
// - K used for sources 010,101,110,111
// - K acts as index or multiplier
// - direct write stores; transfer bit moves output
// - direct commands 48h and 4Ch, reset zero
// - write-through 4Ah/4Eh updates input and output
// - host DAC write overrides calculated code
// - bit 4 shorts channel 2 amplifier
// - bit 3 shorts channel 1 amplifier
// - bit 2 picks acquisition or tracking
// - one-shot bit runs calibration, self-clears
// - one-shot with periodic restarts 13ms timer
// - periodic bit repeats calibration every 15ms
// - alarm enable bits 5,3,1
// - window mode bits 4,2,0
// - calibration control command 5Eh
// - alarm config write 3Eh, read BEh
module gdc_regs
  import gdc_pkg::*;
#(
  parameter int unsigned CAL_PERIOD_CYC = `GDC_CAL_PERIOD_CYC,
  parameter int unsigned CAL_RESTART_CYC = `GDC_CAL_RESTART_CYC,
  parameter int unsigned CAL_RUN_CYC = `GDC_CAL_RUN_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command write and read from the serial decoder
  input wire logic wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_cmd,
  output logic [15:0] rd_data_ff,
  output logic rd_valid_ff,
  // configuration from the software configuration and load registers
  input wire logic [1:0] load_select,
  input wire logic [1:0][2:0] k_source_select,
  input wire logic [1:0] k_mult_mode,
  input wire logic [1:0] dac_transfer_bit,
  // code calculation handshake, index 0 is channel 1
  output logic [1:0] calc_start_ff,
  output logic [1:0][11:0] setpoint_code_ff,
  output logic [1:0][11:0] k_parameter_ff,
  output logic [1:0] k_index_en_ff,
  output logic [1:0] k_mult_en_ff,
  input wire logic [1:0] calc_done,
  input wire logic [1:0][11:0] computed_dac_code,
  // dac registers
  output logic [1:0][11:0] dac_input_ff,
  output logic [1:0][11:0] dac_output_ff,
  // calibration and alarm controls
  output gdc_cal_ctrl_t cal_ctrl_ff,
  output logic cal_active_ff,
  output logic cal_tracking_ff,
  output gdc_alarm_cfg_t alarm_cfg_ff
);

  // ****************************************
  // per channel code registers
  // ****************************************
  localparam logic [7:0] CMD_SP [2] = '{`GDC_CMD_CH1_SETPOINT, `GDC_CMD_CH2_SETPOINT};
  localparam logic [7:0] CMD_K [2] = '{`GDC_CMD_CH1_K_PARAM, `GDC_CMD_CH2_K_PARAM};
  localparam logic [7:0] CMD_DIR [2] = '{`GDC_CMD_CH1_DAC_DIRECT, `GDC_CMD_CH2_DAC_DIRECT};
  localparam logic [7:0] CMD_THR [2] = '{`GDC_CMD_CH1_DAC_THRU, `GDC_CMD_CH2_DAC_THRU};

  logic [11:0] wr_code;
  logic [1:0] wr_sp, wr_k, wr_dir, wr_thr;

  assign wr_code = wr_data[`GDC_CODE_MSB:0]; // top nibble is don't care

  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign wr_sp[g] = wr_en && (wr_cmd == CMD_SP[g]);
    assign wr_k[g] = wr_en && (wr_cmd == CMD_K[g]);
    assign wr_dir[g] = wr_en && (wr_cmd == CMD_DIR[g]);
    assign wr_thr[g] = wr_en && (wr_cmd == CMD_THR[g]);

    // setpoint store and calculation kick, one pulse per write
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        setpoint_code_ff[g] <= `GDC_CODE_RESET;
        calc_start_ff[g] <= 1'b0;
      end else begin
        calc_start_ff[g] <= wr_sp[g];
        if (wr_sp[g]) begin
          setpoint_code_ff[g] <= wr_code;
        end
      end
    end

    // k parameter has no reset value, so it is never cleared
    always_ff @(posedge clk_sys) begin
      if (wr_k[g]) begin
        k_parameter_ff[g] <= wr_code;
      end
    end

    // k usage decode kept combinational so the flops below see only non-blocking updates
    logic use_k;
    always_comb begin
      use_k = 1'b0;
      case (k_source_select[g])
        3'b010, 3'b101, 3'b110, 3'b111: use_k = 1'b1;
        default: use_k = 1'b0;
      endcase
    end

    // k usage flags follow the live source selection
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        k_index_en_ff[g] <= 1'b0;
        k_mult_en_ff[g] <= 1'b0;
      end else begin
        k_index_en_ff[g] <= use_k && !k_mult_mode[g];
        k_mult_en_ff[g] <= use_k && k_mult_mode[g];
      end
    end

    // host writes sit above the calculated code so a same-cycle result cannot undo them
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        dac_input_ff[g] <= `GDC_CODE_RESET;
      end else if (wr_dir[g] || wr_thr[g]) begin
        dac_input_ff[g] <= wr_code;
      end else if (calc_done[g]) begin
        dac_input_ff[g] <= computed_dac_code[g];
      end
    end

    // output register: write-through, then calculation, then transfer
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        dac_output_ff[g] <= `GDC_CODE_RESET;
      end else if (wr_thr[g]) begin
        dac_output_ff[g] <= wr_code;
      end else if (calc_done[g] && load_select[g] && !wr_dir[g]) begin
        dac_output_ff[g] <= computed_dac_code[g];
      end else if (dac_transfer_bit[g]) begin
        dac_output_ff[g] <= dac_input_ff[g];
      end
    end

    sp_write_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_sp[g] |=> calc_start_ff[g] && setpoint_code_ff[g] == $past(wr_code))
      else $error("setpoint write did not start a calculation");
    calc_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      calc_done[g] && !wr_dir[g] && !wr_thr[g]
      |=> dac_input_ff[g] == $past(computed_dac_code[g])
      && (dac_output_ff[g] == $past(computed_dac_code[g])) == $past(load_select[g])
      || $past(dac_input_ff[g]) == $past(computed_dac_code[g]))
      else $error("calculated code loaded into the wrong registers");
    direct_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_dir[g] && !dac_transfer_bit[g]
      |=> dac_input_ff[g] == $past(wr_code) && $stable(dac_output_ff[g]))
      else $error("direct write disturbed the dac output");
    // write-through outranks a same-cycle result on both registers, so no exception is needed
    thru_both_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_thr[g]
      |=> dac_input_ff[g] == dac_output_ff[g] && dac_output_ff[g] == $past(wr_code))
      else $error("write-through did not update both registers");
    k_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      k_source_select[g] inside {3'b000, 3'b001, 3'b011, 3'b100}
      |=> !k_index_en_ff[g] && !k_mult_en_ff[g])
      else $error("k parameter used for a source that excludes it");
  end

  // ****************************************
  // calibration control
  // ****************************************
  logic wr_cal;
  logic cal_end;
  gdc_cal_state_t cal_state_ff;
  logic [31:0] cal_tmr_ff;

  assign wr_cal = wr_en && (wr_cmd == `GDC_CMD_CAL_CTRL_WR);
  assign cal_end = (cal_state_ff == GDC_CAL_RUN) && (cal_tmr_ff == 32'h0000_0000);

  // stored bits; one-shot clears when its run ends unless rewritten that cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_ctrl_ff <= '0;
    end else if (wr_cal) begin
      // bits above the channel 2 short field are simply not stored
      cal_ctrl_ff.ch2_input_short <= wr_data[`GDC_CAL_CH2_SHORT_BIT];
      cal_ctrl_ff.ch1_input_short <= wr_data[`GDC_CAL_CH1_SHORT_BIT];
      cal_ctrl_ff.track <= wr_data[`GDC_CAL_TRACK_BIT];
      cal_ctrl_ff.run_calibration_once <= wr_data[`GDC_CAL_ONCE_BIT];
      cal_ctrl_ff.periodic_calibration <= wr_data[`GDC_CAL_PERIODIC_BIT];
    end else if (cal_end) begin
      cal_ctrl_ff.run_calibration_once <= 1'b0;
    end
  end

  // sequencer: one timer counts the run length and the gap between runs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_state_ff <= GDC_CAL_IDLE;
      cal_tmr_ff <= 32'h0000_0000;
      cal_tracking_ff <= 1'b0;
    end else begin
      case (cal_state_ff)
        GDC_CAL_IDLE: begin
          if (cal_ctrl_ff.run_calibration_once) begin
            cal_state_ff <= GDC_CAL_RUN;
            cal_tmr_ff <= 32'(CAL_RUN_CYC - 1);
            cal_tracking_ff <= cal_ctrl_ff.track;
          end else if (cal_ctrl_ff.periodic_calibration) begin
            cal_state_ff <= GDC_CAL_WAIT;
            cal_tmr_ff <= 32'(CAL_PERIOD_CYC - 1);
          end
        end
        GDC_CAL_WAIT: begin
          if (cal_ctrl_ff.run_calibration_once || cal_tmr_ff == 32'h0000_0000) begin
            cal_state_ff <= GDC_CAL_RUN;
            cal_tmr_ff <= 32'(CAL_RUN_CYC - 1);
            cal_tracking_ff <= cal_ctrl_ff.track;
          end else if (!cal_ctrl_ff.periodic_calibration) begin
            cal_state_ff <= GDC_CAL_IDLE; // periodic bit dropped: stop the timer
          end else begin
            cal_tmr_ff <= cal_tmr_ff - 32'h0000_0001;
          end
        end
        GDC_CAL_RUN: begin
          if (cal_tmr_ff != 32'h0000_0000) begin
            cal_tmr_ff <= cal_tmr_ff - 32'h0000_0001;
          end else if (cal_ctrl_ff.periodic_calibration) begin
            cal_state_ff <= GDC_CAL_WAIT;
            // a commanded run restarts the timer on the shorter gap
            cal_tmr_ff <= cal_ctrl_ff.run_calibration_once ?
              32'(CAL_RESTART_CYC - 1) : 32'(CAL_PERIOD_CYC - 1);
          end else begin
            cal_state_ff <= GDC_CAL_IDLE;
          end
        end
        default: begin
          cal_state_ff <= GDC_CAL_IDLE;
        end
      endcase
    end
  end

  // run flag mirrors the sequencer state as a clean output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_active_ff <= 1'b0;
    end else begin
      cal_active_ff <= (cal_state_ff == GDC_CAL_RUN);
    end
  end

  sequence s_run_ends_commanded;
    cal_end && cal_ctrl_ff.run_calibration_once && cal_ctrl_ff.periodic_calibration;
  endsequence
  sequence s_timer_restarted;
    cal_state_ff == GDC_CAL_WAIT && cal_tmr_ff == 32'(CAL_RESTART_CYC - 1);
  endsequence
  sequence s_gap_elapsed;
    cal_state_ff == GDC_CAL_WAIT && cal_tmr_ff == 32'h0000_0000
    && !cal_ctrl_ff.run_calibration_once;
  endsequence

  short_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_cal |=> cal_ctrl_ff.ch2_input_short == $past(wr_data[4])
    && cal_ctrl_ff.ch1_input_short == $past(wr_data[3]))
    else $error("input short bits do not follow the write");
  once_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    cal_end && !wr_cal |=> !cal_ctrl_ff.run_calibration_once)
    else $error("one-shot bit not cleared at end of run");
  once_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_cal && wr_data[1] && cal_state_ff != GDC_CAL_RUN
    |=> ##1 cal_state_ff == GDC_CAL_RUN ##1 cal_active_ff)
    else $error("one-shot write did not start a run");
  timer_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_run_ends_commanded |=> s_timer_restarted)
    else $error("timer not restarted on the short gap");
  periodic_run_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_gap_elapsed |=> cal_state_ff == GDC_CAL_RUN
    && cal_tmr_ff == 32'(CAL_RUN_CYC - 1))
    else $error("periodic calibration did not run when the gap ended");
  bits_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_cal |=> $stable(cal_ctrl_ff.track) && $stable(cal_ctrl_ff.periodic_calibration)
    && $stable(cal_ctrl_ff.ch1_input_short))
    else $error("calibration bit changed without a write");

  // ****************************************
  // alarm configuration and read back
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_cfg_ff <= `GDC_ALARM_CFG_RESET;
    end else if (wr_en && wr_cmd == `GDC_CMD_ALARM_CFG_WR) begin
      alarm_cfg_ff <= wr_data[`GDC_ALARM_CFG_MSB:0];
    end
  end

  // only the alarm configuration reads back; other read commands return zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_en) begin
        rd_data_ff <= (rd_cmd == `GDC_CMD_ALARM_CFG_RD) ?
          {10'h000, alarm_cfg_ff} : 16'h0000;
      end
    end
  end

  alarm_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_en && wr_cmd == 8'h3e |=> alarm_cfg_ff.ch1_gate_volt_alarm_en == $past(wr_data[5])
    && alarm_cfg_ff.ch1_sense_window == $past(wr_data[0]))
    else $error("alarm configuration not stored from the write");
  alarm_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    rd_en && rd_cmd == 8'hbe && !(wr_en && wr_cmd == 8'h3e)
    |=> rd_valid_ff && rd_data_ff == {10'h000, $past(alarm_cfg_ff)})
    else $error("alarm configuration read back wrong");

endmodule : gdc_regs

// >>> shared/gdc_defs.svh
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH

// ****************************************
// command bytes
// ****************************************
`define GDC_CMD_CH1_SETPOINT 8'h40
`define GDC_CMD_CH2_SETPOINT 8'h42
`define GDC_CMD_CH1_K_PARAM 8'h44
`define GDC_CMD_CH2_K_PARAM 8'h46
`define GDC_CMD_CH1_DAC_DIRECT 8'h48
`define GDC_CMD_CH1_DAC_THRU 8'h4a
`define GDC_CMD_CH2_DAC_DIRECT 8'h4c
`define GDC_CMD_CH2_DAC_THRU 8'h4e
`define GDC_CMD_CAL_CTRL_WR 8'h5e
`define GDC_CMD_ALARM_CFG_WR 8'h3e
`define GDC_CMD_ALARM_CFG_RD 8'hbe

// ****************************************
// field positions and reset values
// ****************************************
`define GDC_CODE_MSB 11
`define GDC_CAL_CH2_SHORT_BIT 4
`define GDC_CAL_CH1_SHORT_BIT 3
`define GDC_CAL_TRACK_BIT 2
`define GDC_CAL_ONCE_BIT 1
`define GDC_CAL_PERIODIC_BIT 0
`define GDC_ALARM_CFG_MSB 5
`define GDC_CODE_RESET 12'h000
`define GDC_ALARM_CFG_RESET 6'h00

// ****************************************
// timing
// ****************************************
`define GDC_CLK_FREQ_MHZ 200
`define GDC_CAL_PERIOD_MS 15
`define GDC_CAL_RESTART_MS 13
`define GDC_CAL_PERIOD_CYC (`GDC_CAL_PERIOD_MS * 1000 * `GDC_CLK_FREQ_MHZ)
`define GDC_CAL_RESTART_CYC (`GDC_CAL_RESTART_MS * 1000 * `GDC_CLK_FREQ_MHZ)
`define GDC_CAL_RUN_CYC 256

`endif

// >>> shared/gdc_pkg.sv
package gdc_pkg;

  // calibration control bits as stored
  typedef struct packed {
    logic ch2_input_short;
    logic ch1_input_short;
    logic track;
    logic run_calibration_once;
    logic periodic_calibration;
  } gdc_cal_ctrl_t;

  // channel 1 alarm enables and window modes, bit order as written
  typedef struct packed {
    logic ch1_gate_volt_alarm_en;
    logic ch1_gate_volt_window;
    logic ch1_temp_alarm_en;
    logic ch1_temp_window;
    logic ch1_sense_alarm_en;
    logic ch1_sense_window;
  } gdc_alarm_cfg_t;

  typedef enum logic [1:0] {
    GDC_CAL_IDLE = 2'b00,
    GDC_CAL_WAIT = 2'b01,
    GDC_CAL_RUN = 2'b10
  } gdc_cal_state_t;

endpackage : gdc_pkg

// >>> tb/gdc_calc_model.sv
module gdc_calc_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request from the register bank
  input wire logic [1:0] calc_start,
  input wire logic [1:0][11:0] setpoint_code,
  input wire logic [1:0][11:0] k_parameter,
  input wire logic [1:0] k_mult_en,
  // answer to the register bank
  output logic [1:0] calc_done,
  output logic [1:0][11:0] computed_dac_code
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0][3:0] cnt_ff;

  // ****************************************
  // per channel delayed calculator
  // ****************************************
  // code is only meaningful with done; otherwise it toggles so stale data is never trusted
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      calc_done[g] <= 1'b0;
      computed_dac_code[g] <= ~computed_dac_code[g];
      if (rst) begin
        cnt_ff[g] <= 4'h0;
        computed_dac_code[g] <= 12'h5a5;
      end else if (calc_start[g]) begin
        cnt_ff[g] <= 4'(DELAY);
      end else if (cnt_ff[g] == 4'h1) begin
        cnt_ff[g] <= 4'h0;
        calc_done[g] <= 1'b1;
        // multiplier mode passes k through, else a simple stand-in result
        computed_dac_code[g] <= k_mult_en[g] ? k_parameter[g] : setpoint_code[g] + 12'h001;
      end else if (cnt_ff[g] != 4'h0) begin
        cnt_ff[g] <= cnt_ff[g] - 4'h1;
      end
    end
  end
endmodule : gdc_calc_model

// >>> tb/tb.sv
module tb
  import gdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals and design under test
  // ****************************************
  localparam int PER = 40;
  localparam int RESTART = 30;
  localparam int RUN = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic [7:0] wr_cmd = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic rd_en = 1'b0;
  logic [7:0] rd_cmd = 8'h00;
  logic [1:0] load_select = 2'h0;
  logic [1:0][2:0] k_source_select = '0;
  logic [1:0] k_mult_mode = 2'h0;
  logic [1:0] dac_transfer_bit = 2'h0;
  logic [1:0] calc_done;
  logic [1:0][11:0] computed_dac_code;
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  logic [1:0] calc_start_ff, k_index_en_ff, k_mult_en_ff;
  logic [1:0][11:0] setpoint_code_ff, k_parameter_ff, dac_input_ff, dac_output_ff;
  gdc_cal_ctrl_t cal_ctrl_ff;
  logic cal_active_ff, cal_tracking_ff, e;
  gdc_alarm_cfg_t alarm_cfg_ff;
  int bad_count = 0;
  int compares = 0;
  int n;

  // short timer counts keep the run small; expectations derive from them
  gdc_regs #(.CAL_PERIOD_CYC(PER), .CAL_RESTART_CYC(RESTART), .CAL_RUN_CYC(RUN)) DUT (
    .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .rd_en(rd_en), .rd_cmd(rd_cmd), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .load_select(load_select), .k_source_select(k_source_select), .k_mult_mode(k_mult_mode),
    .dac_transfer_bit(dac_transfer_bit), .calc_start_ff(calc_start_ff),
    .setpoint_code_ff(setpoint_code_ff), .k_parameter_ff(k_parameter_ff),
    .k_index_en_ff(k_index_en_ff), .k_mult_en_ff(k_mult_en_ff), .calc_done(calc_done),
    .computed_dac_code(computed_dac_code), .dac_input_ff(dac_input_ff),
    .dac_output_ff(dac_output_ff), .cal_ctrl_ff(cal_ctrl_ff), .cal_active_ff(cal_active_ff),
    .cal_tracking_ff(cal_tracking_ff), .alarm_cfg_ff(alarm_cfg_ff)
  );

  gdc_calc_model #(.DELAY(3)) calc_far (
    .clk_sys(clk_sys), .rst(rst), .calc_start(calc_start_ff),
    .setpoint_code(setpoint_code_ff), .k_parameter(k_parameter_ff), .k_mult_en(k_mult_en_ff),
    .calc_done(calc_done), .computed_dac_code(computed_dac_code)
  );

  // free running 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe; returns just after the edge that took it
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_cmd <= c;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    rd_cmd <= c;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk({15'h0000, rd_valid_ff}, 16'h0001);
    chk(rd_data_ff, exp);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : idle

  // counts edges until the run flag reaches lvl, bounded by lim
  task automatic wait_cal(input logic lvl, input int lim);
    n = 0;
    while (cal_active_ff !== lvl && n < lim) begin
      idle(1);
      n++;
    end
  endtask : wait_cal

  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    load_select <= 2'h1;
    idle(1);
    chk({4'h0, setpoint_code_ff[0] | setpoint_code_ff[1]}, 16'h0000);
    chk({4'h0, dac_input_ff[0] | dac_input_ff[1]}, 16'h0000);
    chk({5'h00, cal_ctrl_ff, alarm_cfg_ff}, 16'h0000);
    // ch1 loads input and output from the calculation, then host writes override
    wr(8'h40, 16'hf123);
    chk({14'h0000, calc_start_ff}, 16'h0001);
    chk({4'h0, setpoint_code_ff[0]}, 16'h0123);
    idle(8);
    chk({4'h0, dac_input_ff[0]}, 16'h0124);
    chk({4'h0, dac_output_ff[0]}, 16'h0124);
    wr(8'h48, 16'ha555);
    chk({4'h0, dac_input_ff[0]}, 16'h0555);
    chk({4'h0, dac_output_ff[0]}, 16'h0124);
    @(posedge clk_sys);
    dac_transfer_bit <= 2'h1;
    @(posedge clk_sys);
    dac_transfer_bit <= 2'h0;
    idle(1);
    chk({4'h0, dac_output_ff[0]}, 16'h0555);
    wr(8'h4a, 16'h0fff);
    chk({4'h0, dac_input_ff[0]}, 16'h0fff);
    chk({4'h0, dac_output_ff[0]}, 16'h0fff);
    // ch2 selects input only
    wr(8'h42, 16'h0800);
    idle(8);
    chk({4'h0, dac_input_ff[1]}, 16'h0801);
    chk({4'h0, dac_output_ff[1]}, 16'h0000);
    wr(8'h4e, 16'h1234);
    chk({4'h0, dac_output_ff[1]}, 16'h0234);
    wr(8'h4c, 16'h5abc);
    chk({4'h0, dac_input_ff[1]}, 16'h0abc);
    chk({4'h0, dac_output_ff[1]}, 16'h0234);
    // k registers and every source selection, ch1 as index, ch2 as multiplier
    wr(8'h44, 16'hfabc);
    wr(8'h46, 16'h8123);
    chk({4'h0, k_parameter_ff[0]}, 16'h0abc);
    chk({4'h0, k_parameter_ff[1]}, 16'h0123);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys);
      k_mult_mode <= 2'h2;
      k_source_select <= {3'(s), 3'(s)};
      idle(2);
      e = (s == 2) || (s >= 5);
      chk({12'h000, k_index_en_ff, k_mult_en_ff}, {12'h000, 1'b0, e, e, 1'b0});
    end
    // alarm bits in both polarities, read back and a non-readable command
    wr(8'h3e, 16'hffea);
    chk({10'h000, alarm_cfg_ff}, 16'h002a);
    rd(8'hbe, 16'h002a);
    wr(8'h3e, 16'h0015);
    rd(8'hbe, 16'h0015);
    rd(8'h3e, 16'h0000);
    // shorting bits without a run, then a one-shot run in tracking mode
    wr(8'h5e, 16'hffdc);
    chk({11'h000, cal_ctrl_ff}, 16'h001c);
    wait_cal(1'b1, 20);
    chk(16'(n), 16'h0014);
    wr(8'h5e, 16'hffe6);
    chk({11'h000, cal_ctrl_ff}, 16'h0006);
    wait_cal(1'b1, 4);
    chk({15'h0000, cal_tracking_ff}, 16'h0001);
    wait_cal(1'b0, 20);
    chk(16'(n), 16'(RUN));
    chk({11'h000, cal_ctrl_ff}, 16'h0004);
    // self-timed runs: first wait and gap between runs use the full period
    wr(8'h5e, 16'h0001);
    wait_cal(1'b1, 60);
    chk(16'(n >= PER - 3 && n <= PER + 4), 16'h0001);
    chk({15'h0000, cal_tracking_ff}, 16'h0000);
    wait_cal(1'b0, 20);
    chk({11'h000, cal_ctrl_ff}, 16'h0001);
    wait_cal(1'b1, 60);
    chk(16'(n >= PER - 3 && n <= PER + 4), 16'h0001);
    // one-shot with self-timing restarts the shorter timer
    wait_cal(1'b0, 20);
    wr(8'h5e, 16'h0003);
    wait_cal(1'b1, 4);
    chk({15'h0000, cal_active_ff}, 16'h0001);
    wait_cal(1'b0, 20);
    wait_cal(1'b1, 60);
    chk(16'(n >= RESTART - 3 && n <= RESTART + 4), 16'h0001);
    // clearing self-timing stops further runs
    wr(8'h5e, 16'h0000);
    wait_cal(1'b0, 20);
    wait_cal(1'b1, 60);
    chk(16'(n), 16'h003c);
    final_report;
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    final_report;
  end
endmodule : tb
